// *** core/sfmgr_regs.svh ***
// register offsets, field positions and reset values of the safety manager block
`ifndef SFMGR_REGS_SVH
`define SFMGR_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define SFMGR_OFS_CLOCK_CTRL 12'h000
`define SFMGR_OFS_STATUS 12'h004
`define SFMGR_OFS_ALARM_ZERO 12'h008
`define SFMGR_OFS_ALARM_SEVEN 12'h00C
`define SFMGR_OFS_RUN_ERR 12'h010
`define SFMGR_OFS_RUN_STS 12'h014
`define SFMGR_OFS_PIN_CTRL 12'h018
`define SFMGR_OFS_PORT_IN 12'h01C
`define SFMGR_OFS_IRQ_STATUS 12'h020
`define SFMGR_OFS_IRQ_MASK 12'h024
`define SFMGR_OFS_MEMTEST_STS 12'h028
`define SFMGR_OFS_MEMTEST_CLR 12'h02C
`define SFMGR_ADDR_MEMTEST_ECC 32'hF0063810
`define SFMGR_ADDR_MEMTEST_FAULT 32'hF00638F0

// ----------------------------------------------------------------
// fields and resets
// ----------------------------------------------------------------
`define SFMGR_CLC_DISABLE_BIT 0
`define SFMGR_CLC_RESET 32'h00000000
`define SFMGR_ALARM_SEVEN_RESET 32'h00000003
`define SFMGR_STS_PIN_LEVEL_BIT 0
`define SFMGR_STS_CORE_OFF_BIT 1
`define SFMGR_STS_FLOAT_BIT 2
`define SFMGR_PIN_MODE_LSB 0
`define SFMGR_PIN_ESTOP_EN_BIT 2
`define SFMGR_IRQ_ALARM_BIT 0
`define SFMGR_IRQ_ESTOP_BIT 1
`define SFMGR_IRQ_CORE_OFF_BIT 2
`define SFMGR_IRQ_STBY_FAULT_BIT 3
`define SFMGR_IRQ_W 4
`define SFMGR_TOGGLE_DIV 16'h04E1

`endif

// *** core/sfmgr_pkg.sv ***
// types of the safety manager block
package sfmgr_pkg;
  typedef enum logic [1:0] {
    SFMGR_SIG_BISTABLE,
    SFMGR_SIG_DUAL_RAIL,
    SFMGR_SIG_TIME_SWITCH,
    SFMGR_SIG_OFF
  } sfmgr_sig_mode_t;
  typedef enum {
    SFMGR_PIN_NORMAL,
    SFMGR_PIN_FAULT,
    SFMGR_PIN_FLOAT
  } sfmgr_pin_state_t;
endpackage

// *** core/sfmgr_sync.sv ***
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfmgr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** core/sfmgr_top.sv ***
// safety manager alarm flags, clock control and error pin with apb slave
`timescale 1ns/1ps
`default_nettype none
`include "sfmgr_regs.svh"
module sfmgr_top (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // alarm sources
  input wire logic [31:0] alarm_zero_in,
  input wire logic [31:0] alarm_seven_in,
  input wire logic [31:0] run_err_in,
  input wire logic [31:0] run_sts_in,
  input wire logic stby_fault_in,
  input wire logic memtest40_alarm_in,
  input wire logic clc_upset_in,
  // error output pin
  input wire logic err_pin_in,
  output logic err_pin_out,
  output logic err_pin_oe_out,
  // reactions
  output logic alarm_action_out,
  output logic estop_out,
  output logic irq_out
);
  import sfmgr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_sync;
  sfmgr_sync #(.W(4)) u_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .d_in({err_pin_in, stby_fault_in, memtest40_alarm_in, clc_upset_in}),
    .q_out(pins_sync)
  );
  logic pin_level;
  logic stby_fault;
  logic mt40_alarm;
  logic clc_upset;
  assign pin_level = pins_sync[3];
  assign stby_fault = pins_sync[2];
  assign mt40_alarm = pins_sync[1];
  assign clc_upset = pins_sync[0];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic ofs_ok;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  always_comb begin
    case (paddr_in)
      `SFMGR_OFS_CLOCK_CTRL, `SFMGR_OFS_STATUS, `SFMGR_OFS_ALARM_ZERO,
      `SFMGR_OFS_ALARM_SEVEN, `SFMGR_OFS_RUN_ERR, `SFMGR_OFS_RUN_STS,
      `SFMGR_OFS_PIN_CTRL, `SFMGR_OFS_PORT_IN, `SFMGR_OFS_IRQ_STATUS,
      `SFMGR_OFS_IRQ_MASK, `SFMGR_OFS_MEMTEST_STS, `SFMGR_OFS_MEMTEST_CLR: ofs_ok = 1'b1;
      default: ofs_ok = 1'b0;
    endcase
  end
  logic w_clc;
  logic w_az;
  logic w_ag7;
  logic w_rerr;
  logic w_rsts;
  logic w_pin;
  logic w_mask;
  logic w_mtclr;
  logic r_irq;
  assign w_clc = wr_en && paddr_in == `SFMGR_OFS_CLOCK_CTRL;
  assign w_az = wr_en && paddr_in == `SFMGR_OFS_ALARM_ZERO;
  assign w_ag7 = wr_en && paddr_in == `SFMGR_OFS_ALARM_SEVEN;
  assign w_rerr = wr_en && paddr_in == `SFMGR_OFS_RUN_ERR;
  assign w_rsts = wr_en && paddr_in == `SFMGR_OFS_RUN_STS;
  assign w_pin = wr_en && paddr_in == `SFMGR_OFS_PIN_CTRL;
  assign w_mask = wr_en && paddr_in == `SFMGR_OFS_IRQ_MASK;
  assign w_mtclr = wr_en && paddr_in == `SFMGR_OFS_MEMTEST_CLR;
  assign r_irq = rd_en && paddr_in == `SFMGR_OFS_IRQ_STATUS;

  // ----------------------------------------------------------------
  // clock control
  // ----------------------------------------------------------------
  logic [31:0] clc_reg;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clc_reg <= `SFMGR_CLC_RESET;
    end else if (clc_upset) begin
      // an upset disables the core part and raises the core-off interrupt
      clc_reg[`SFMGR_CLC_DISABLE_BIT] <= 1'b1;
    end else if (w_clc) begin
      clc_reg <= pwdata_in;
    end
  end
  logic core_off;
  assign core_off = clc_reg[`SFMGR_CLC_DISABLE_BIT];

  // ----------------------------------------------------------------
  // alarm flag registers
  // ----------------------------------------------------------------
  logic [31:0] az_reg;
  logic [31:0] ag7_reg;
  logic [31:0] rerr_reg;
  logic [31:0] rsts_reg;
  logic por_seen_reg;
  logic [1:0] por_sync_reg;

  // power-on reset is an async pin; released into this domain by two flops
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_sync_reg <= 2'b00;
    end else begin
      por_sync_reg <= {por_sync_reg[0], por_in};
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_seen_reg <= 1'b0;
    end else begin
      por_seen_reg <= por_sync_reg[1];
    end
  end

  // bitwise clear: one bits clear, new events win over the clear
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      az_reg <= 32'h00000000;
    end else if (!core_off) begin
      az_reg <= (az_reg & ~(w_az ? pwdata_in : 32'h00000000)) | alarm_zero_in;
    end
  end

  // set by every reset; clear of bits 1:0 held off while memtest 40 still alarms
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ag7_reg <= `SFMGR_ALARM_SEVEN_RESET;
    end else if (por_seen_reg) begin
      ag7_reg <= ag7_reg | `SFMGR_ALARM_SEVEN_RESET;
    end else if (!core_off) begin
      ag7_reg <= (ag7_reg & ~((w_ag7 ? pwdata_in : 32'h00000000) &
                 (mt40_alarm ? ~`SFMGR_ALARM_SEVEN_RESET : 32'hFFFFFFFF))) | alarm_seven_in;
    end
  end

  // run-mode flags: zero bits clear, so 0xFFFFFFFB clears flag two only
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rerr_reg <= 32'h00000000;
    end else begin
      rerr_reg <= (rerr_reg & (w_rerr ? pwdata_in : 32'hFFFFFFFF)) | run_err_in;
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rsts_reg <= 32'h00000000;
    end else begin
      rsts_reg <= (rsts_reg & (w_rsts ? pwdata_in : 32'hFFFFFFFF)) | run_sts_in;
    end
  end

  // ----------------------------------------------------------------
  // alarm reaction
  // ----------------------------------------------------------------
  // reaction follows raw alarms, so a stray clear cannot suppress it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alarm_action_out <= 1'b0;
    end else begin
      alarm_action_out <= !core_off && ((|alarm_zero_in) || (|alarm_seven_in) || (|run_err_in));
    end
  end

  // ----------------------------------------------------------------
  // memtest controller 40 status
  // ----------------------------------------------------------------
  logic [15:0] mt_fault_reg;
  logic [15:0] mt_ecc_reg;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mt_fault_reg <= 16'h0000;
      mt_ecc_reg <= 16'h0000;
    end else if (mt40_alarm) begin
      mt_fault_reg <= 16'h0001;
      mt_ecc_reg <= 16'h0001;
    end else if (w_mtclr) begin
      mt_fault_reg <= mt_fault_reg & pwdata_in[15:0];
      mt_ecc_reg <= mt_ecc_reg & pwdata_in[31:16];
    end
  end

  // ----------------------------------------------------------------
  // error pin
  // ----------------------------------------------------------------
  logic [31:0] pin_ctrl_reg;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_ctrl_reg <= 32'h00000000;
    end else if (w_pin) begin
      pin_ctrl_reg <= pwdata_in;
    end
  end
  sfmgr_sig_mode_t sig_mode;
  assign sig_mode = sfmgr_sig_mode_t'(pin_ctrl_reg[`SFMGR_PIN_MODE_LSB +: 2]);

  logic [15:0] div_reg;
  logic toggle_tick;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_reg <= 16'h0000;
    end else if (div_reg == `SFMGR_TOGGLE_DIV) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  assign toggle_tick = div_reg == `SFMGR_TOGGLE_DIV;

  sfmgr_pin_state_t pin_state;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_state <= SFMGR_PIN_NORMAL;
    end else begin
      case (pin_state)
        SFMGR_PIN_NORMAL: begin
          if (stby_fault) begin
            pin_state <= SFMGR_PIN_FLOAT;
          end else if (|az_reg && !core_off) begin
            pin_state <= SFMGR_PIN_FAULT;
          end
        end
        SFMGR_PIN_FAULT: begin
          if (stby_fault) begin
            pin_state <= SFMGR_PIN_FLOAT;
          end else if (az_reg == 32'h00000000) begin
            pin_state <= SFMGR_PIN_NORMAL;
          end
        end
        SFMGR_PIN_FLOAT: begin
          if (!stby_fault) begin
            pin_state <= SFMGR_PIN_NORMAL;
          end
        end
        default: pin_state <= SFMGR_PIN_NORMAL;
      endcase
    end
  end

  logic pin_float;
  assign pin_float = pin_state == SFMGR_PIN_FLOAT;

  // standby fault releases the pin; external pull defines the level
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_pin_out <= 1'b0;
      err_pin_oe_out <= 1'b0;
    end else begin
      err_pin_oe_out <= !pin_float && sig_mode != SFMGR_SIG_OFF;
      case (sig_mode)
        SFMGR_SIG_BISTABLE: err_pin_out <= pin_state == SFMGR_PIN_NORMAL;
        SFMGR_SIG_DUAL_RAIL, SFMGR_SIG_TIME_SWITCH: begin
          if (pin_state == SFMGR_PIN_FAULT) begin
            err_pin_out <= 1'b0;
          end else if (toggle_tick && !core_off) begin
            // disabled core freezes the toggle, so the monitor sees the stall
            err_pin_out <= !err_pin_out;
          end
        end
        default: err_pin_out <= 1'b0;
      endcase
    end
  end

  // emergency stop from the pin, blocked while it floats
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      estop_out <= 1'b0;
    end else begin
      estop_out <= pin_ctrl_reg[`SFMGR_PIN_ESTOP_EN_BIT] && !pin_float && !pin_level;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`SFMGR_IRQ_W-1:0] irq_sts_reg;
  logic [`SFMGR_IRQ_W-1:0] irq_mask_reg;
  logic [`SFMGR_IRQ_W-1:0] irq_ev;
  assign irq_ev = {stby_fault, core_off, estop_out, alarm_action_out};
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_sts_reg <= '0;
    end else begin
      irq_sts_reg <= (r_irq ? '0 : irq_sts_reg) | irq_ev;
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask_reg <= '0;
    end else if (w_mask) begin
      irq_mask_reg <= pwdata_in[`SFMGR_IRQ_W-1:0];
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((r_irq ? '0 : irq_sts_reg) | irq_ev) & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic [31:0] sts_word;
  always_comb begin
    sts_word = 32'h00000000;
    // floating pin is not reported as a valid level
    sts_word[`SFMGR_STS_PIN_LEVEL_BIT] = pin_float ? 1'b0 : pin_level;
    sts_word[`SFMGR_STS_CORE_OFF_BIT] = core_off;
    sts_word[`SFMGR_STS_FLOAT_BIT] = pin_float;
  end
  always_comb begin
    case (paddr_in)
      `SFMGR_OFS_CLOCK_CTRL: rd_data = clc_reg;
      `SFMGR_OFS_STATUS: rd_data = sts_word;
      `SFMGR_OFS_ALARM_ZERO: rd_data = az_reg;
      `SFMGR_OFS_ALARM_SEVEN: rd_data = ag7_reg;
      `SFMGR_OFS_RUN_ERR: rd_data = rerr_reg;
      `SFMGR_OFS_RUN_STS: rd_data = rsts_reg;
      `SFMGR_OFS_PIN_CTRL: rd_data = pin_ctrl_reg;
      `SFMGR_OFS_PORT_IN: rd_data = {31'h00000000, pin_float ? 1'b0 : pin_level};
      `SFMGR_OFS_IRQ_STATUS: rd_data = {28'h0000000, irq_sts_reg};
      `SFMGR_OFS_IRQ_MASK: rd_data = {28'h0000000, irq_mask_reg};
      `SFMGR_OFS_MEMTEST_STS: rd_data = {mt_ecc_reg, mt_fault_reg};
      default: rd_data = 32'h00000000;
    endcase
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !ofs_ok;
      if (psel_in && !penable_in) begin
        prdata_out <= rd_data;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/sfmgr_chk_sva.sv ***
// port-level assertion checker for the safety manager block
`timescale 1ns/1ps
`default_nettype none
module sfmgr_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // alarm sources and reactions
  input wire logic [31:0] alarm_zero_in,
  input wire logic [31:0] alarm_seven_in,
  input wire logic [31:0] run_err_in,
  input wire logic stby_fault_in,
  input wire logic err_pin_oe_out,
  input wire logic estop_out,
  input wire logic alarm_action_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_setup_gets_ready: assert property (psel_in && !penable_in |=> pready_out)
    else $error("setup not answered in next cycle");
  a_ready_one_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held over two cycles");
  a_idle_no_ready: assert property (!psel_in |=> !pready_out)
    else $error("ready without a request");
  a_unmapped_error: assert property (psel_in && !penable_in && paddr_in > 12'h02C |=> pslverr_out)
    else $error("unmapped access without error");
  a_unmapped_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h00000000)
    else $error("unmapped read returned data");
  a_rdata_holds: assert property (!$past(psel_in) |-> $stable(prdata_out))
    else $error("read data moved without a setup");
  a_float_oe_off: assert property (stby_fault_in [*5] |-> !err_pin_oe_out)
    else $error("pin still driven during standby fault");
  a_float_no_estop: assert property (stby_fault_in [*5] |-> !estop_out)
    else $error("emergency stop while pin floats");
  a_no_cause_quiet: assert property (
    !(|alarm_zero_in || |alarm_seven_in || |run_err_in) |=> !alarm_action_out)
    else $error("alarm action without a raw alarm");
endmodule
bind sfmgr_top sfmgr_chk i_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .alarm_zero_in(alarm_zero_in), .alarm_seven_in(alarm_seven_in),
  .run_err_in(run_err_in), .stby_fault_in(stby_fault_in), .err_pin_oe_out(err_pin_oe_out),
  .estop_out(estop_out), .alarm_action_out(alarm_action_out)
);
`default_nettype wire

// *** test/sfmgr_monitor.sv ***
// external safety monitor at the error output pin
`timescale 1ns/1ps
`default_nettype none
module sfmgr_monitor (
  // clock
  input wire logic mclk_in,
  // pin drive from the block
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  // board pull level and edge counter clear
  input wire logic pull_hi_in,
  input wire logic clr_in,
  // observed line
  output logic pin_level_out,
  output logic [15:0] edges_out
);
  logic last_reg;
  // released line rests at the board pull, never at the last driven value
  assign pin_level_out = pin_oe_in ? pin_out_in : pull_hi_in;
  // a stalled dynamic protocol shows as a frozen edge count
  always_ff @(posedge mclk_in) begin
    last_reg <= pin_level_out;
    if (clr_in)
      edges_out <= 16'h0000;
    else if (last_reg != pin_level_out)
      edges_out <= edges_out + 16'h0001;
  end
endmodule
`default_nettype wire

// *** test/test_safety_alarm_flag_handling.sv ***
// self-checking bench for the safety manager block
`timescale 1ns/1ps
`default_nettype none
`include "sfmgr_regs.svh"
module test_safety_alarm_flag_handling;
  import sfmgr_pkg::*;
  logic mclk_in, sys_rst_in, por_in, psel, penable, pwrite, pready, pslverr;
  logic stby, mt40, upset, pull_hi, clr_e, pin_i, pin_o, pin_oe, act, estop, irq, ia, ib;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [31:0] src [4];
  logic [11:0] ofs [4];
  logic [15:0] edges;
  logic [32:0] expq [$];
  int error_cnt, cmp_count;
  sfmgr_top i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .por_in(por_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .alarm_zero_in(src[0]), .alarm_seven_in(src[1]),
    .run_err_in(src[2]), .run_sts_in(src[3]), .stby_fault_in(stby), .memtest40_alarm_in(mt40),
    .clc_upset_in(upset), .err_pin_in(pin_i), .err_pin_out(pin_o), .err_pin_oe_out(pin_oe),
    .alarm_action_out(act), .estop_out(estop), .irq_out(irq));
  sfmgr_monitor i_mon (.mclk_in(mclk_in), .pin_out_in(pin_o), .pin_oe_in(pin_oe), .pull_hi_in(pull_hi),
    .clr_in(clr_e), .pin_level_out(pin_i), .edges_out(edges));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // reads queue {slverr, data}; the watcher below pops at the answer edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, expq.pop_front());
  end
  task idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // raw alarms are one-cycle events; reaction lands one edge later
  task pulse(input int k, input logic [31:0] val, input logic en);
    src[k] <= val;
    @(posedge mclk_in);
    src[k] <= 32'h00000000;
    #1 chk(act, k != 3 && en);
    @(posedge mclk_in);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    sys_rst_in = 1'b1;
    por_in = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    src = '{4{32'h00000000}};
    ofs = '{`SFMGR_OFS_ALARM_ZERO, `SFMGR_OFS_ALARM_SEVEN, `SFMGR_OFS_RUN_ERR, `SFMGR_OFS_RUN_STS};
    {stby, upset, pull_hi} = '0;
    {mt40, clr_e} = 2'b11;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(57));
    idle(8);
    sys_rst_in <= 1'b0;
    por_in <= 1'b0;
    clr_e <= 1'b0;
    @(posedge mclk_in);
    apb(0, `SFMGR_OFS_ALARM_SEVEN, 0, 33'h3);
    apb(1, `SFMGR_OFS_ALARM_SEVEN, 32'h00000003, 0);
    apb(0, `SFMGR_OFS_ALARM_SEVEN, 0, 33'h3);
    mt40 <= 1'b0;
    // alarm pin needs two flops before the clear can stick
    idle(3);
    apb(1, `SFMGR_OFS_MEMTEST_CLR, 32'h00000000, 0);
    apb(0, `SFMGR_OFS_MEMTEST_STS, 0, 33'h0);
    apb(1, `SFMGR_OFS_ALARM_SEVEN, 32'h00000003, 0);
    apb(0, `SFMGR_OFS_ALARM_SEVEN, 0, 33'h0);
    por_in <= 1'b1;
    idle(4);
    por_in <= 1'b0;
    apb(0, `SFMGR_OFS_ALARM_SEVEN, 0, 33'h3);
    for (int k = 0; k < 4; k++) begin
      apb(1, ofs[k], k < 2 ? 32'hFFFFFFFF : 32'h00000000, 0);
      v = $urandom | 32'h00000005;
      pulse(k, v, 1'b1);
      apb(1, ofs[k], k < 2 ? 32'h00000004 : 32'hFFFFFFFB, 0);
      apb(0, ofs[k], 0, {1'b0, v & 32'hFFFFFFFB});
    end
    // mask polarity is probed, then the enabling value is kept
    apb(1, `SFMGR_OFS_IRQ_MASK, 32'h0000000F, 0);
    #1 ia = irq;
    apb(1, `SFMGR_OFS_IRQ_MASK, 32'h00000000, 0);
    #1 ib = irq;
    chk(ia, 1'b1);
    chk(ib, 1'b0);
    apb(1, `SFMGR_OFS_IRQ_MASK, 32'h0000000F, 0);
    apb(0, `SFMGR_OFS_IRQ_STATUS, 0, 33'h1);
    apb(0, `SFMGR_OFS_IRQ_STATUS, 0, 33'h0);
    chk(irq, 1'b0);
    apb(1, `SFMGR_OFS_PIN_CTRL, 32'h00000003, 0);
    idle(1);
    chk(pin_oe, 1'b0);
    // pending group-zero flags would hold the pin in its fault level
    apb(1, `SFMGR_OFS_ALARM_ZERO, 32'hFFFFFFFF, 0);
    apb(1, `SFMGR_OFS_PIN_CTRL, {30'h00000000, SFMGR_SIG_DUAL_RAIL}, 0);
    clr_e <= 1'b1;
    idle(1);
    clr_e <= 1'b0;
    idle(2600);
    chk(edges >= 16'h0002, 1'b1);
    apb(1, `SFMGR_OFS_PIN_CTRL, {30'h00000000, SFMGR_SIG_TIME_SWITCH}, 0);
    clr_e <= 1'b1;
    idle(1);
    clr_e <= 1'b0;
    idle(2600);
    chk(edges >= 16'h0002, 1'b1);
    upset <= 1'b1;
    idle(4);
    upset <= 1'b0;
    clr_e <= 1'b1;
    idle(1);
    clr_e <= 1'b0;
    apb(0, `SFMGR_OFS_CLOCK_CTRL, 0, 33'h1);
    idle(2600);
    chk(edges, 16'h0000);
    pulse(0, 32'h00000001, 1'b0);
    apb(0, `SFMGR_OFS_ALARM_ZERO, 0, 33'h0);
    apb(1, `SFMGR_OFS_CLOCK_CTRL, 32'h00000000, 0);
    apb(0, `SFMGR_OFS_CLOCK_CTRL, 0, 33'h0);
    apb(0, `SFMGR_OFS_IRQ_STATUS, 0, 33'h4);
    apb(1, `SFMGR_OFS_PIN_CTRL, 32'h00000004, 0);
    stby <= 1'b1;
    idle(6);
    chk(pin_oe, 1'b0);
    chk(estop, 1'b0);
    pull_hi <= 1'b1;
    idle(4);
    apb(0, `SFMGR_OFS_STATUS, 0, 33'h4);
    apb(0, `SFMGR_OFS_PORT_IN, 0, 33'h0);
    stby <= 1'b0;
    apb(0, 12'h030, 0, 33'h100000000);
    sys_rst_in <= 1'b1;
    idle(2);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    apb(0, `SFMGR_OFS_ALARM_SEVEN, 0, 33'h3);
    tally_and_finish;
  end
endmodule
`default_nettype wire
